// ### logic/prs_sequencer.sv
// supply supervision and power-on-reset bring-up sequencer
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] watch battery and core supply, start on battery startup level, reset when either falls below shutdown.
// [R2] comparator levels are 0.70 V monitor, 0.82 V +-50 mV battery startup, 0.80 V +-50 mV shutdown.
// [R3] at sequence start audio is off and all control state is asynchronously reset to defaults.
// [R4] core registers are held cleared during power-on reset, RAM contents are left unspecified.
// [R5] supply stabilisation completes before boot ROM initialisation starts.
// [R6] regulators settle, then charge pump settles, then clock is distributed, then external clock is selected.
// [R7] reset release only after core supply stays above startup level for the whole qualification time.
// [R8] a dip below core shutdown level shuts down and needs a fresh full qualification to restart.
// [R9] a supply failure shuts down every functional unit, the audio path included.
// [R10] once running only a fall below shutdown level stops the system, giving hysteresis.
// [R11] the internal oscillator clocks only boot and standby, normal running needs the external clock.
// [R12] during boot the core regulator setting is driven to its maximum.
// [R13] the charge pump refresh is timed from a rate divided from the slow clock.
// [R14] qualification and settle waits are counters on the internal oscillator with parameter lengths.
module prs_sequencer
    import prs_pkg::*;
#(
    parameter logic [TIMER_W-1:0] QUALIFY_LEN = QUALIFY_CYCLES,
    parameter logic [TIMER_W-1:0] REG_SETTLE_LEN = REG_SETTLE_CYCLES,
    parameter logic [TIMER_W-1:0] PUMP_SETTLE_LEN = PUMP_SETTLE_CYCLES,
    parameter logic [TIMER_W-1:0] REFRESH_LEN = REFRESH_DIV_CYCLES
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic monitorActive,
    input wire logic batteryAboveStartup,
    input wire logic batteryAboveShutdown,
    input wire logic coreAboveStartup,
    input wire logic coreAboveShutdown,
    input wire logic extClockPresent,
    input wire logic bootDone,
    output logic regulatorEnable,
    output logic chargePumpEnable,
    output logic clockDistribute,
    output logic extClockSelect,
    output logic audioOutputEnable,
    output logic coreResetn,
    output logic bootStart,
    output logic [REG_SET_W-1:0] coreRegSetting,
    output logic chargePumpRefresh,
    output logic systemRunning
);

    typedef struct packed {
        prs_state_e state;
        logic regEn;
        logic pumpEn;
        logic clkDist;
        logic extSel;
        logic audioEn;
        logic coreRstn;
        logic bootGo;
        logic [REG_SET_W-1:0] regSetting;
        logic [TIMER_W-1:0] qualRun;
    } prs_seq_s;

    prs_seq_s st;
    prs_seq_s next_st;

    logic supplyFail;
    logic waitLoad;
    logic [TIMER_W-1:0] waitValue;
    logic waitDone;
    logic refreshLoad;
    logic refreshDone;
    logic refreshBusy;

    // core supply only counts once its regulator has been qualified
    always_comb begin
        supplyFail = !monitorActive || !batteryAboveShutdown; // R1 R2 R9
        if (st.state != PRS_OFF && st.state != PRS_QUALIFY) begin
            supplyFail = supplyFail || !coreAboveShutdown; // R1 R8
        end
    end

    always_comb begin
        next_st = st;
        next_st.bootGo = 1'b0;
        if (st.state != PRS_OFF && supplyFail) begin
            // everything off and back into reset at once
            next_st = '0; // R9 R3
            next_st.state = PRS_OFF;
            next_st.regSetting = CORE_REG_DEFAULT;
        end else begin
            unique case (st.state)
                PRS_OFF: begin
                    if (monitorActive && batteryAboveStartup) begin // R1 R2
                        next_st.state = PRS_QUALIFY;
                        next_st.regEn = 1'b1;
                    end
                end
                PRS_QUALIFY: begin
                    if (waitDone && coreAboveStartup) begin // R7
                        next_st.state = PRS_REG_WAIT;
                    end
                end
                PRS_REG_WAIT: begin
                    if (waitDone) begin // R6
                        next_st.state = PRS_PUMP_WAIT;
                        next_st.pumpEn = 1'b1;
                    end
                end
                PRS_PUMP_WAIT: begin
                    if (waitDone) begin // R6
                        next_st.state = PRS_CLK_DIST;
                        next_st.clkDist = 1'b1;
                    end
                end
                PRS_CLK_DIST: begin
                    next_st.state = PRS_EXT_SWITCH; // R6
                end
                PRS_EXT_SWITCH: begin
                    // no external clock means staying on the oscillator, boot not yet started
                    if (extClockPresent) begin // R11
                        next_st.extSel = 1'b1;
                        next_st.state = PRS_BOOT; // R5
                        next_st.bootGo = 1'b1;
                        next_st.coreRstn = 1'b1; // R4
                        next_st.regSetting = CORE_REG_MAX; // R12
                    end
                end
                PRS_BOOT: begin
                    if (bootDone) begin
                        next_st.state = PRS_RUN;
                        next_st.audioEn = 1'b1;
                    end
                end
                PRS_RUN: begin
                    next_st.state = PRS_RUN; // R10
                end
            endcase
        end
        // qualification helper: consecutive cycles of core supply above startup
        if (!coreAboveStartup || st.state != PRS_QUALIFY) begin
            next_st.qualRun = '0;
        end else if (st.qualRun != '1) begin
            next_st.qualRun = st.qualRun + TIMER_ONE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0; // R3
        end else begin
            st <= next_st;
        end
    end

    // restart the qualification whenever the core supply is not above startup
    assign waitLoad = (next_st.state != st.state) || (st.state == PRS_QUALIFY && !coreAboveStartup); // R8 R14

    always_comb begin
        unique case (next_st.state)
            PRS_QUALIFY: waitValue = QUALIFY_LEN; // R14
            PRS_REG_WAIT: waitValue = REG_SETTLE_LEN; // R14
            PRS_PUMP_WAIT: waitValue = PUMP_SETTLE_LEN; // R14
            default: waitValue = TIMER_ONE;
        endcase
    end

    prs_timer waitTimer (
        .clk(clk),
        .resetn(resetn),
        .load(waitLoad),
        .loadValue(waitValue),
        .expired(waitDone),
        .busy()
    );

    // refresh rate divided down from the oscillator while the pump runs
    assign refreshLoad = st.pumpEn && (refreshDone || !refreshBusy); // R13

    prs_timer refreshTimer (
        .clk(clk),
        .resetn(resetn),
        .load(refreshLoad),
        .loadValue(REFRESH_LEN),
        .expired(refreshDone),
        .busy(refreshBusy)
    );

    assign chargePumpRefresh = st.pumpEn && refreshDone; // R13
    assign regulatorEnable = st.regEn;
    assign chargePumpEnable = st.pumpEn;
    assign clockDistribute = st.clkDist;
    assign extClockSelect = st.extSel;
    assign audioOutputEnable = st.audioEn;
    assign coreResetn = st.coreRstn;
    assign bootStart = st.bootGo;
    assign coreRegSetting = st.regSetting;
    assign systemRunning = (st.state == PRS_RUN);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_fail_shuts_down: assert property (st.state != PRS_OFF && supplyFail |=> st.state == PRS_OFF && !audioOutputEnable && !regulatorEnable) // R9
        else $error("supply failure did not shut down");
    a_monitor_levels: assert property (st.state == PRS_OFF && !(monitorActive && batteryAboveStartup) |=> st.state == PRS_OFF) // R1
        else $error("started below battery startup level");
    a_off_in_reset: assert property (st.state == PRS_OFF |-> !coreResetn && !audioOutputEnable) // R3
        else $error("reset state not held while off");
    a_core_cleared: assert property (coreResetn |-> st.state == PRS_BOOT || st.state == PRS_RUN) // R4
        else $error("core reset released before boot");
    a_boot_after_stab: assert property (bootStart |-> extClockSelect && clockDistribute && chargePumpEnable && regulatorEnable) // R5
        else $error("boot started before stabilisation");
    a_pump_after_reg: assert property ($rose(chargePumpEnable) |-> regulatorEnable ##1 !clockDistribute) // R6
        else $error("charge pump order broken");
    a_qualify_time: assert property (st.state == PRS_QUALIFY && next_st.state == PRS_REG_WAIT |-> st.qualRun >= QUALIFY_LEN) // R7
        else $error("qualification time too short");
    a_dip_requalify: assert property (st.state == PRS_QUALIFY && !coreAboveStartup |=> st.state != PRS_REG_WAIT) // R8
        else $error("dip did not restart qualification");
    a_run_holds: assert property (st.state == PRS_RUN && !supplyFail |=> st.state == PRS_RUN) // R10
        else $error("run stopped above shutdown level");
    a_ext_clock: assert property ($rose(extClockSelect) |-> $past(extClockPresent)) // R11
        else $error("external clock selected while absent");
    a_reg_max: assert property (st.state == PRS_BOOT |-> coreRegSetting == CORE_REG_MAX) // R12
        else $error("regulator setting not maximum in boot");
    a_refresh_pump: assert property (chargePumpRefresh |=> !chargePumpRefresh) // R13
        else $error("refresh pulse longer than one cycle");
    a_settle_wait: assert property ($rose(chargePumpEnable) |-> !clockDistribute [*2]) // R14
        else $error("pump settle wait skipped");

    c_reach_run: cover property (st.state == PRS_BOOT ##1 st.state == PRS_RUN);
    c_run_fail: cover property (st.state == PRS_RUN ##1 st.state == PRS_OFF);
    c_qual_restart: cover property (st.state == PRS_QUALIFY && !coreAboveStartup ##1 st.state == PRS_QUALIFY);
    c_refresh: cover property (chargePumpRefresh);

endmodule
`default_nettype wire

// ### include/prs_pkg.sv
// shared constants and types of the power-on-reset sequencer
package prs_pkg;

    // comparator trip points in millivolts, fixed in the analog front end
    localparam int MONITOR_ACTIVE_MV = 700;
    localparam int BATTERY_STARTUP_MV = 820;
    localparam int BATTERY_STARTUP_TOL_MV = 50;
    localparam int SHUTDOWN_MV = 800;
    localparam int SHUTDOWN_TOL_MV = 50;

    // wait lengths in internal oscillator cycles; plain defaults
    localparam int TIMER_W = 24;
    localparam logic [TIMER_W-1:0] QUALIFY_CYCLES = 24'h00_03E8;
    localparam logic [TIMER_W-1:0] REG_SETTLE_CYCLES = 24'h00_0100;
    localparam logic [TIMER_W-1:0] PUMP_SETTLE_CYCLES = 24'h00_0100;
    localparam logic [TIMER_W-1:0] REFRESH_DIV_CYCLES = 24'h00_0040;
    localparam logic [TIMER_W-1:0] TIMER_ONE = 24'h00_0001;

    // core regulator setting
    localparam int REG_SET_W = 4;
    localparam logic [REG_SET_W-1:0] CORE_REG_DEFAULT = 4'h0;
    localparam logic [REG_SET_W-1:0] CORE_REG_MAX = 4'hF;

    typedef enum logic [2:0] {
        PRS_OFF,
        PRS_QUALIFY,
        PRS_REG_WAIT,
        PRS_PUMP_WAIT,
        PRS_CLK_DIST,
        PRS_EXT_SWITCH,
        PRS_BOOT,
        PRS_RUN
    } prs_state_e;

endpackage

// ### logic/prs_timer.sv
// loadable down counter used for qualification, settle waits and refresh timing
`timescale 1ns/1ps
`default_nettype none
module prs_timer
    import prs_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [TIMER_W-1:0] loadValue,
    output logic expired,
    output logic busy
);

    typedef struct packed {
        logic [TIMER_W-1:0] count;
        logic running;
    } prs_timer_s;

    prs_timer_s st;
    prs_timer_s next_st;

    always_comb begin
        next_st = st;
        if (load) begin
            // zero would expire at once without any wait, so a load never goes below one
            next_st.count = (loadValue == '0) ? TIMER_ONE : loadValue;
            next_st.running = 1'b1;
        end else if (st.running && st.count != '0) begin
            next_st.count = st.count - TIMER_ONE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign expired = st.running && (st.count == '0);
    assign busy = st.running;

endmodule
`default_nettype wire

// ### bench/prs_supply_model.sv
// behavioural model of supply comparators, boot rom and external clock source
`timescale 1ns/1ps
`default_nettype none
module prs_supply_model
    import prs_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] batteryMv,
    input wire logic [15:0] coreMv,
    input wire logic extClockOn,
    input wire logic bootStart,
    output logic monitorActive,
    output logic batteryAboveStartup,
    output logic batteryAboveShutdown,
    output logic coreAboveStartup,
    output logic coreAboveShutdown,
    output logic extClockPresent,
    output logic bootDone
);
    // nominal trip points only; the tolerance band is left out so levels between them are exact
    assign monitorActive = batteryMv >= 16'(MONITOR_ACTIVE_MV);
    assign batteryAboveStartup = batteryMv >= 16'(BATTERY_STARTUP_MV);
    assign batteryAboveShutdown = batteryMv >= 16'(SHUTDOWN_MV);
    assign coreAboveStartup = coreMv >= 16'(BATTERY_STARTUP_MV);
    assign coreAboveShutdown = coreMv >= 16'(SHUTDOWN_MV);
    assign extClockPresent = extClockOn;
    // boot rom finishes one cycle after start and forgets it once the supply fails
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bootDone <= 1'b0;
        end else if (!batteryAboveShutdown || !coreAboveShutdown) begin
            bootDone <= 1'b0;
        end else if (bootStart) begin
            bootDone <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### bench/prs_sequencer_tb_top.sv
// self-checking bench of the power-on-reset sequencer
`timescale 1ns/1ps
`default_nettype none
module prs_sequencer_tb_top
    import prs_pkg::*;
;
    localparam int QL = 6;
    localparam int RL = 2;
    localparam int PL = 2;
    localparam int FL = 3;
    localparam logic [15:0] NOM = 16'(BATTERY_STARTUP_MV + 100);
    localparam logic [15:0] MID = 16'(SHUTDOWN_MV + 10);
    localparam logic [15:0] LOW = 16'(SHUTDOWN_MV - 100);
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] batteryMv = 16'h0000;
    logic [15:0] coreMv = 16'h0000;
    logic extClockOn = 1'b0;
    logic monitorActive, batteryAboveStartup, batteryAboveShutdown, coreAboveStartup, coreAboveShutdown;
    logic extClockPresent, bootDone, regulatorEnable, chargePumpEnable, clockDistribute, extClockSelect;
    logic audioOutputEnable, coreResetn, bootStart, chargePumpRefresh, systemRunning;
    logic [REG_SET_W-1:0] coreRegSetting;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    prs_sequencer #(.QUALIFY_LEN(TIMER_W'(QL)), .REG_SETTLE_LEN(TIMER_W'(RL)), .PUMP_SETTLE_LEN(TIMER_W'(PL)),
        .REFRESH_LEN(TIMER_W'(FL))) u_dut (.clk, .resetn, .monitorActive, .batteryAboveStartup,
        .batteryAboveShutdown, .coreAboveStartup, .coreAboveShutdown, .extClockPresent, .bootDone,
        .regulatorEnable, .chargePumpEnable, .clockDistribute, .extClockSelect, .audioOutputEnable,
        .coreResetn, .bootStart, .coreRegSetting, .chargePumpRefresh, .systemRunning);
    prs_supply_model u_model (.clk, .resetn, .batteryMv, .coreMv, .extClockOn, .bootStart, .monitorActive,
        .batteryAboveStartup, .batteryAboveShutdown, .coreAboveStartup, .coreAboveShutdown,
        .extClockPresent, .bootDone);
    always #2 clk = ~clk;
    task automatic give_verdict();
        $display("compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // a generous ceiling; the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic check_bits(input logic [3:0] got, input logic [3:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic check_count(input int got, input int lo, input int hi, input string what);
        compares++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("wrong value at %0t: %s count %0d", $time, what, got);
        end
    endtask
    function automatic logic stage(input int i);
        case (i)
            0: return regulatorEnable;
            1: return chargePumpEnable;
            2: return clockDistribute;
            3: return extClockSelect;
            default: return systemRunning;
        endcase
    endfunction
    // bounded wait; outputs are looked at 1 ns after each edge so its updates have landed
    task automatic wait_stage(input int i, output int k);
        k = 0;
        while (stage(i) !== 1'b1 && k < 200) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask
    task automatic set_supply(input logic [15:0] b, input logic [15:0] c, input logic e);
        @(posedge clk);
        batteryMv <= b;
        coreMv <= c;
        extClockOn <= e;
    endtask
    task automatic off_check(input string what);
        check_bits({regulatorEnable, chargePumpEnable, clockDistribute, extClockSelect}, 4'h0, what);
        check_bits({audioOutputEnable, coreResetn, bootStart, systemRunning}, 4'h0, what);
    endtask
    task automatic test_reset();
        @(posedge clk);
        resetn <= 1'b0;
        batteryMv <= NOM;
        coreMv <= NOM;
        repeat (5) @(posedge clk);
        #1;
        off_check("outputs in reset");
        check_bits(coreRegSetting, CORE_REG_DEFAULT, "regulator default");
        set_supply(16'h0000, 16'h0000, 1'b0);
        resetn <= 1'b1;
        $display("test reset done");
    endtask
    task automatic test_bring_up();
        set_supply(NOM, NOM, 1'b1);
        wait_stage(0, n);
        check_count(n, 1, 2, "regulator start");
        wait_stage(1, n);
        check_count(n, QL + RL, QL + RL + 4, "qualify and regulator settle");
        check_bits({chargePumpEnable, clockDistribute, extClockSelect, coreResetn}, 4'h8, "pump stage");
        wait_stage(2, n);
        check_count(n, PL, PL + 3, "pump settle");
        check_bits({clockDistribute, extClockSelect, coreResetn, bootStart}, 4'h8, "clock stage");
        wait_stage(3, n);
        check_count(n, 1, 2, "external switch");
        check_bits({extClockSelect, coreResetn, bootStart, audioOutputEnable}, 4'hE, "boot start");
        check_bits(coreRegSetting, CORE_REG_MAX, "regulator max in boot");
        wait_stage(4, n);
        check_count(n, 1, 3, "boot to run");
        check_bits({audioOutputEnable, systemRunning, bootStart, coreResetn}, 4'hD, "running");
        $display("test bring_up done");
    endtask
    task automatic test_no_ext_clock();
        test_reset();
        set_supply(NOM, NOM, 1'b0);
        wait_stage(3, n);
        check_count(n, 200, 200, "waits for external clock");
        check_bits({coreResetn, audioOutputEnable, clockDistribute, bootStart}, 4'h2, "held on oscillator");
        set_supply(NOM, NOM, 1'b1);
        wait_stage(3, n);
        check_count(n, 1, 3, "switch once clock present");
        $display("test no_ext_clock done");
    endtask
    task automatic test_qualify_dip();
        test_reset();
        set_supply(NOM, NOM, 1'b1);
        wait_stage(0, n);
        repeat (QL - 2) @(posedge clk);
        coreMv <= MID;
        @(posedge clk);
        coreMv <= NOM;
        wait_stage(1, n);
        check_count(n, QL + RL, QL + RL + 4, "qualify restarts after dip");
        $display("test qualify_dip done");
    endtask
    task automatic test_run_hysteresis();
        int pulses;
        pulses = 0;
        set_supply(MID, MID, 1'b1);
        repeat (10 * (FL + 1)) begin
            @(posedge clk);
            #1;
            pulses += int'(chargePumpRefresh === 1'b1);
        end
        check_count(pulses, 9, 11, "refresh rate");
        check_bits({systemRunning, audioOutputEnable, coreResetn, extClockSelect}, 4'hF, "hysteresis");
        set_supply(MID, LOW, 1'b1);
        @(posedge clk);
        coreMv <= NOM;
        #1;
        off_check("core shutdown");
        check_bits(coreRegSetting, CORE_REG_DEFAULT, "regulator back to default");
        repeat (10) @(posedge clk);
        #1;
        check_bits({regulatorEnable, chargePumpRefresh, chargePumpEnable, bootStart}, 4'h0, "no start");
        test_bring_up();
        set_supply(LOW, NOM, 1'b1);
        @(posedge clk);
        #1;
        off_check("battery shutdown");
        $display("test run_hysteresis done");
    endtask
    initial begin
        test_reset();
        test_bring_up();
        test_run_hysteresis();
        test_qualify_dip();
        test_no_ext_clock();
        give_verdict();
    end
endmodule
`default_nettype wire
